// ===== common/fbh_defs.svh
// Constants for the fieldbus request header handler: bit positions, limits, codes.
// Assumes inclusion by bare name from package and design files alike.
`ifndef FBH_DEFS_SVH
`define FBH_DEFS_SVH
`define FBH_EXT_BIT 3'h7
`define FBH_REQ_DONE_BIT 3'h6
`define FBH_RESP_READ_BIT 3'h5
`define FBH_RES_HI_BIT 3'h4
`define FBH_RES_LO_BIT 3'h3
`define FBH_BROADCAST_ADDR 7'h7f
`define FBH_MAX_LEN_EXP 8'hf4
`define FBH_MAX_LEN_STD 8'hf6
`define FBH_L4_LEN_NONE 6'h00
`define FBH_L4_LEN_FIXED 6'h02
`define FBH_L4_LEN_MAX 6'h20
`define FBH_L4_SEL_NONE 2'h0
`define FBH_L4_SEL_FIXED 2'h1
`define FBH_L4_SEL_ONE 2'h2
`define FBH_L4_SEL_TWO 2'h3
`define FBH_DEFAULT_SAP 8'hff
`define FBH_FC_SDA_LO 4'h3
`define FBH_FC_SDN_LO 4'h4
`define FBH_FC_SDA_HI 4'h5
`define FBH_FC_SDN_HI 4'h6
`define FBH_FC_STATUS 4'h9
`define FBH_FC_SRD_LO 4'hc
`define FBH_FC_SRD_HI 4'hd
`define FBH_FC_TOP_PLAIN 2'h0
`define FBH_FC_TOP_LOCAL_ONLY 2'h3
`define FBH_WRITE_CONSISTENCY_BIT_BIT 3'h5
`define FBH_RX_COUNT_BIT 3'h5
`define FBH_RX_COUNT_VALID_BIT 3'h4
`define FBH_SEG_SHIFT 4
`define FBH_LIN_ADDR_W 20
`define FBH_FIFO_DEPTH 8
`endif

// ===== common/fbh_pkg.sv
// Types shared by the header handler, its FIFO carrier and the bench.
// Assumes fbh_defs.svh is on the include path.
`default_nettype none
`include "fbh_defs.svh"
package fbh_pkg;
  typedef struct packed {
    logic [`FBH_LIN_ADDR_W-1:0] buf_addr;
    logic [7:0] data_len;
    logic [7:0] dest_addr;
    logic [7:0] src_addr;
    logic [7:0] func_code;
    logic [7:0] dest_sap;
    logic [7:0] src_sap;
    logic [5:0] l4_len;
    logic broadcast;
  } tx_header_t;
  typedef enum logic [1:0] {st_idle, st_check, st_push} state_t;
  localparam int TX_HEADER_W = $bits(tx_header_t);
endpackage
`default_nettype wire

// ===== common/hdr_stream_if.sv
// Valid/ready word stream between the header handler and its FIFO.
// Assumes one clock for both ends.
`default_nettype none
interface hdr_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verilog/fbh_fifo.sv
// Synchronous FIFO with valid/ready on both sides, freezable by a clock enable.
// Assumes one clock; depth must be a power of two.
`default_nettype none
`include "fbh_defs.svh"
module fbh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FBH_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  hdr_stream_if.snk in_port,
  hdr_stream_if.src out_port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("fbh_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;
  assign in_port.ready = (count_q != (AW+1)'(DEPTH));
  assign out_port.valid = (count_q != '0);
  assign out_port.data = mem_q[rd_q];
  assign push = in_port.valid && in_port.ready;
  assign pop = out_port.valid && out_port.ready;
  // Storage needs no reset; the count alone says what is valid
  always_ff @(posedge i_clock) begin
    if (i_clk_en && push) begin
      mem_q[wr_q] <= in_port.data;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else if (i_clk_en) begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/fbh_request_header.sv
// Fieldbus request header handler: checks host request headers, builds the
// outgoing frame header into a FIFO, and fills indication block bytes.
// Assumes one clock, host fields steady while i_req_valid is high.
//
// Operation
// - Net data length at most 244 with access-point expansion, else 246.
// - Remote addresses 0..126 are stations; 127 is broadcast or multicast.
// - Indication remote address byte gets received source field as received.
// - Local address comes from the own station address, not the host.
// - Local address byte: bit7 extension, bit6 processed, bit5 response pointer read.
// - Indication local address byte gets received destination field as received.
// - Send data codes 00xy0011, 00xy0100, 00xy0101, 00xy0110.
// - Status request 00xy1001; send and request 00xy1100 low, 00xy1101 high.
// - Local only request never goes onto the line; it forces token pass.
// - Indication function code stores received code without frame count bits.
// - User write consistency bit in function code byte is kept.
// - Remote access point used only when remote extension bit set.
// - Indication remote access point gets source point, or FF for default.
// - Local access point used only when local extension bit set.
// - Indication local access point gets destination point, or FF for default.
// - Layer-4 length fixed 2 or two configured lengths of at most 32.
// - Layer-4 length chosen per request and per indication by own selector.
// - Selector 00 none, 01 two bytes, 10 length one, 11 length two.
`default_nettype none
`include "fbh_defs.svh"
module fbh_request_header #(
  parameter int FIFO_DEPTH = `FBH_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_address_format_select,
  input wire logic [6:0] i_own_station_address_reg,
  input wire logic [5:0] i_l4_length_one,
  input wire logic [5:0] i_l4_length_two,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [31:0] i_request_buffer_pointer,
  input wire logic [7:0] i_req_data_length,
  input wire logic [7:0] i_rem_addr,
  input wire logic [7:0] i_loc_addr,
  input wire logic [7:0] i_func_code,
  input wire logic [7:0] i_rem_sap,
  input wire logic [7:0] i_loc_sap,
  input wire logic [1:0] i_l4_header_length_select,
  input wire logic i_resp_ptr_read,
  output logic [7:0] o_loc_addr_wb,
  output logic o_loc_addr_wb_valid,
  output logic o_local_only,
  output logic o_req_error,
  output logic o_err_length,
  output logic o_err_reserved,
  output logic o_err_func,
  output logic o_err_l4_cfg,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output fbh_pkg::tx_header_t o_tx_header,
  input wire logic i_ind_valid,
  input wire logic [7:0] i_rx_src_addr,
  input wire logic [7:0] i_rx_dest_addr,
  input wire logic [7:0] i_rx_func_code,
  input wire logic [7:0] i_rx_src_sap,
  input wire logic [7:0] i_rx_dest_sap,
  input wire logic i_rx_src_default,
  input wire logic i_rx_dest_default,
  input wire logic [7:0] i_ind_fc_byte,
  input wire logic [1:0] i_ind_l4_select,
  output logic o_ind_valid,
  output logic [7:0] o_ind_rem_addr,
  output logic [7:0] o_ind_loc_addr,
  output logic [7:0] o_ind_func_code,
  output logic [7:0] o_ind_rem_sap,
  output logic [7:0] o_ind_loc_sap,
  output logic [5:0] o_ind_l4_len,
  output logic o_ind_l4_err
);
  import fbh_pkg::*;

  generate
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
      $error("fbh_request_header: FIFO_DEPTH must be a power of two");
    end
  endgenerate

  state_t state_q;
  logic [31:0] ptr_q;
  logic [7:0] len_q;
  logic [7:0] rem_addr_q;
  logic [7:0] loc_addr_q;
  logic [7:0] fc_q;
  logic [7:0] rem_sap_q;
  logic [7:0] loc_sap_q;
  logic [1:0] l4_sel_q;
  logic accept;
  logic fc_known;
  logic is_local_only;
  logic bad_len;
  logic bad_res;
  logic bad_l4;
  logic any_err;
  logic [5:0] req_l4_len;
  logic req_l4_err;
  logic [5:0] ind_l4_len;
  logic ind_l4_err;
  logic [`FBH_LIN_ADDR_W-1:0] lin_addr;
  tx_header_t hdr_d;
  logic out_load;

  hdr_stream_if #(.WIDTH(TX_HEADER_W)) push_if ();
  hdr_stream_if #(.WIDTH(TX_HEADER_W)) pop_if ();

  fbh_fifo #(
    .WIDTH(TX_HEADER_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .in_port(push_if),
    .out_port(pop_if)
  );

  // Layer-4 length decode shared by both directions
  function automatic logic [6:0] l4_decode(input logic [1:0] sel, input logic [5:0] one,
                                           input logic [5:0] two);
    logic [5:0] len;
    len = `FBH_L4_LEN_NONE;
    case (sel)
      `FBH_L4_SEL_NONE: len = `FBH_L4_LEN_NONE;
      `FBH_L4_SEL_FIXED: len = `FBH_L4_LEN_FIXED;
      `FBH_L4_SEL_ONE: len = one;
      `FBH_L4_SEL_TWO: len = two;
      default: len = `FBH_L4_LEN_NONE;
    endcase
    return {(len > `FBH_L4_LEN_MAX), len};
  endfunction

  assign accept = i_req_valid && o_req_ready;
  assign {req_l4_err, req_l4_len} = l4_decode(l4_sel_q, i_l4_length_one, i_l4_length_two);
  assign {ind_l4_err, ind_l4_len} = l4_decode(i_ind_l4_select, i_l4_length_one,
                                              i_l4_length_two);

  // Function code check over the low nibble; x and y bits pass untouched
  always_comb begin
    case (fc_q[3:0])
      `FBH_FC_SDA_LO, `FBH_FC_SDN_LO, `FBH_FC_SDA_HI, `FBH_FC_SDN_HI: fc_known = 1'b1;
      `FBH_FC_STATUS, `FBH_FC_SRD_LO, `FBH_FC_SRD_HI: fc_known = 1'b1;
      default: fc_known = 1'b0;
    endcase
  end

  assign is_local_only = (fc_q[7:6] == `FBH_FC_TOP_LOCAL_ONLY);
  // Either extension means an expanded access point and two fewer data bytes
  assign bad_len = (rem_addr_q[`FBH_EXT_BIT] || loc_addr_q[`FBH_EXT_BIT]) ?
                   (len_q > `FBH_MAX_LEN_EXP) : (len_q > `FBH_MAX_LEN_STD);
  assign bad_res = loc_addr_q[`FBH_RES_HI_BIT] || loc_addr_q[`FBH_RES_LO_BIT];
  assign bad_l4 = req_l4_err;
  assign any_err = bad_len || bad_res || bad_l4 || (fc_q[7:6] != `FBH_FC_TOP_PLAIN) || !fc_known;

  // Segment:offset gives a 20-bit linear address; a carry past bit 19 wraps
  assign lin_addr = i_address_format_select ?
    (`FBH_LIN_ADDR_W)'({ptr_q[31:16], 4'h0} + {4'h0, ptr_q[15:0]}) :
    ptr_q[`FBH_LIN_ADDR_W-1:0];

  always_comb begin
    hdr_d.buf_addr = lin_addr;
    hdr_d.data_len = len_q;
    hdr_d.dest_addr = rem_addr_q;
    hdr_d.src_addr = {loc_addr_q[`FBH_EXT_BIT], i_own_station_address_reg};
    hdr_d.func_code = fc_q;
    hdr_d.dest_sap = rem_addr_q[`FBH_EXT_BIT] ? rem_sap_q : 8'h00;
    hdr_d.src_sap = loc_addr_q[`FBH_EXT_BIT] ? loc_sap_q : 8'h00;
    hdr_d.l4_len = req_l4_len;
    hdr_d.broadcast = (rem_addr_q[6:0] == `FBH_BROADCAST_ADDR);
  end

  assign push_if.valid = (state_q == st_push);
  assign push_if.data = hdr_d;
  // Output stage takes a word when empty or being drained
  assign out_load = !o_tx_valid || i_tx_ready;
  assign pop_if.ready = out_load && i_clk_en;

  // Request header capture
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q <= 32'h0;
      len_q <= 8'h00;
      rem_addr_q <= 8'h00;
      loc_addr_q <= 8'h00;
      fc_q <= 8'h00;
      rem_sap_q <= 8'h00;
      loc_sap_q <= 8'h00;
      l4_sel_q <= `FBH_L4_SEL_NONE;
    end else if (i_clk_en && accept) begin
      ptr_q <= i_request_buffer_pointer;
      len_q <= i_req_data_length;
      rem_addr_q <= i_rem_addr;
      loc_addr_q <= i_loc_addr;
      fc_q <= i_func_code;
      rem_sap_q <= i_rem_sap;
      loc_sap_q <= i_loc_sap;
      l4_sel_q <= i_l4_header_length_select;
    end
  end

  // Sequencer: one request in flight; a full FIFO holds the host off
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= st_idle;
      o_req_ready <= 1'b1;
    end else if (i_clk_en) begin
      case (state_q)
        st_idle: begin
          if (accept) begin
            state_q <= st_check;
            o_req_ready <= 1'b0;
          end
        end
        st_check: begin
          if (is_local_only || any_err) begin
            state_q <= st_idle;
            o_req_ready <= 1'b1;
          end else begin
            state_q <= st_push;
          end
        end
        st_push: begin
          if (push_if.ready) begin
            state_q <= st_idle;
            o_req_ready <= 1'b1;
          end
        end
        default: begin
          state_q <= st_idle;
          o_req_ready <= 1'b1;
        end
      endcase
    end
  end

  // Check results, one-cycle pulses; error flags hold until the next check
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_local_only <= 1'b0;
      o_req_error <= 1'b0;
      o_err_length <= 1'b0;
      o_err_reserved <= 1'b0;
      o_err_func <= 1'b0;
      o_err_l4_cfg <= 1'b0;
    end else if (i_clk_en) begin
      o_local_only <= (state_q == st_check) && is_local_only;
      o_req_error <= (state_q == st_check) && !is_local_only && any_err;
      if (state_q == st_check) begin
        o_err_length <= bad_len && !is_local_only;
        o_err_reserved <= bad_res && !is_local_only;
        o_err_func <= !is_local_only && ((fc_q[7:6] != `FBH_FC_TOP_PLAIN) || !fc_known);
        o_err_l4_cfg <= bad_l4 && !is_local_only;
      end
    end
  end

  // Local address write-back: processed mark on send, response-read mark later
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_loc_addr_wb <= 8'h00;
      o_loc_addr_wb_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_loc_addr_wb_valid <= 1'b0;
      if (state_q == st_push && push_if.ready) begin
        o_loc_addr_wb <= loc_addr_q;
        o_loc_addr_wb[`FBH_REQ_DONE_BIT] <= 1'b1;
        o_loc_addr_wb[`FBH_RESP_READ_BIT] <= 1'b0;
        o_loc_addr_wb_valid <= 1'b1;
      end else if (i_resp_ptr_read) begin
        o_loc_addr_wb[`FBH_RESP_READ_BIT] <= 1'b1;
        o_loc_addr_wb_valid <= 1'b1;
      end
    end
  end

  // Output stage keeps the top-level header outputs registered
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_valid <= 1'b0;
      o_tx_header <= '0;
    end else if (i_clk_en && out_load) begin
      o_tx_valid <= pop_if.valid;
      if (pop_if.valid) o_tx_header <= tx_header_t'(pop_if.data);
    end
  end

  // Indication block bytes
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ind_valid <= 1'b0;
      o_ind_rem_addr <= 8'h00;
      o_ind_loc_addr <= 8'h00;
      o_ind_func_code <= 8'h00;
      o_ind_rem_sap <= 8'h00;
      o_ind_loc_sap <= 8'h00;
      o_ind_l4_len <= `FBH_L4_LEN_NONE;
      o_ind_l4_err <= 1'b0;
    end else if (i_clk_en) begin
      o_ind_valid <= i_ind_valid;
      if (i_ind_valid) begin
        o_ind_rem_addr <= i_rx_src_addr;
        o_ind_loc_addr <= i_rx_dest_addr;
        o_ind_func_code <= i_rx_func_code;
        o_ind_func_code[`FBH_RX_COUNT_BIT] <= i_ind_fc_byte[`FBH_WRITE_CONSISTENCY_BIT_BIT];
        o_ind_func_code[`FBH_RX_COUNT_VALID_BIT] <= 1'b0;
        o_ind_rem_sap <= i_rx_src_default ? `FBH_DEFAULT_SAP : i_rx_src_sap;
        o_ind_loc_sap <= i_rx_dest_default ? `FBH_DEFAULT_SAP : i_rx_dest_sap;
        o_ind_l4_len <= ind_l4_len;
        o_ind_l4_err <= ind_l4_err;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/fbh_link_model.sv
// Link-side sink that takes outgoing frame headers, stalling on command.
// Assumes the bench drives i_stall at the falling edge.
`default_nettype none
module fbh_link_model (
  input wire logic i_clock,
  input wire logic i_stall,
  input wire logic i_tx_valid,
  input wire fbh_pkg::tx_header_t i_tx_header,
  output logic o_tx_ready
);
  import fbh_pkg::*;
  tx_header_t hdr_q[$];
  initial o_tx_ready = 1'b0;
  // Ready moves off the sampling edge, so a take never races the edge
  always @(negedge i_clock) o_tx_ready <= !i_stall;
  // Only words really sent land here; local-only requests must never show
  always @(posedge i_clock) if (i_tx_valid && o_tx_ready) hdr_q.push_back(i_tx_header);
endmodule
`default_nettype wire

// ===== sim/fbh_request_header_chk.sv
// Port-level timing checks for the header handler.
// Assumes the bind below attaches it to every handler instance.
`default_nettype none
module fbh_request_header_chk (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic [6:0] i_own_station_address_reg,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic [7:0] i_req_data_length,
  input wire logic [7:0] i_rem_addr,
  input wire logic [7:0] i_loc_addr,
  input wire logic [7:0] i_func_code,
  input wire logic i_resp_ptr_read,
  input wire logic [7:0] o_loc_addr_wb,
  input wire logic o_loc_addr_wb_valid,
  input wire logic o_local_only,
  input wire logic o_req_error,
  input wire logic o_tx_valid,
  input wire fbh_pkg::tx_header_t o_tx_header,
  input wire logic i_ind_valid,
  input wire logic [7:0] i_rx_src_addr,
  input wire logic [7:0] i_rx_dest_addr,
  input wire logic [7:0] i_rx_func_code,
  input wire logic [7:0] i_ind_fc_byte,
  input wire logic o_ind_valid,
  input wire logic [7:0] o_ind_rem_addr,
  input wire logic [7:0] o_ind_loc_addr,
  input wire logic [7:0] o_ind_func_code
);
  import fbh_pkg::*;
  logic acc;
  assign acc = i_clk_en && i_req_valid && o_req_ready;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_local_only_pulse: assert property (
    acc && i_func_code[7:6] == 2'h3 |-> ##[1:3] o_local_only)
    else $error("local-only request gave no pulse");
  a_length_refused: assert property (
    acc && i_req_data_length > 8'hf4 && i_rem_addr[7] && i_func_code[7:6] == 2'h0
    |-> ##[1:3] o_req_error) else $error("overlong request not refused");
  a_reserved_refused: assert property (
    acc && i_loc_addr[4:3] != 2'h0 && i_func_code[7:6] == 2'h0 |-> ##[1:3] o_req_error)
    else $error("reserved local bits not refused");
  a_wb_done_mark: assert property (
    o_loc_addr_wb_valid && !o_loc_addr_wb[5] |-> o_loc_addr_wb[6])
    else $error("write-back lacks processed mark");
  a_resp_read_mark: assert property (
    i_clk_en && i_resp_ptr_read && o_req_ready |=> o_loc_addr_wb_valid && o_loc_addr_wb[5])
    else $error("pointer read not marked");
  a_src_own_addr: assert property (
    o_tx_valid |-> o_tx_header.src_addr[6:0] == i_own_station_address_reg)
    else $error("source address not own station");
  a_ind_addr_copy: assert property (
    i_ind_valid && i_clk_en |=> o_ind_valid && o_ind_rem_addr == $past(i_rx_src_addr)
    && o_ind_loc_addr == $past(i_rx_dest_addr)) else $error("indication address wrong");
  a_ind_fc_strip: assert property (
    i_ind_valid && i_clk_en |=> o_ind_func_code ==
    (($past(i_rx_func_code) & 8'hcf) | ($past(i_ind_fc_byte) & 8'h20)))
    else $error("indication function code wrong");
endmodule
bind fbh_request_header fbh_request_header_chk fbh_request_header_chk_i (.i_clock,
  .i_rst_b, .i_clk_en, .i_own_station_address_reg, .i_req_valid, .o_req_ready,
  .i_req_data_length, .i_rem_addr, .i_loc_addr, .i_func_code, .i_resp_ptr_read,
  .o_loc_addr_wb, .o_loc_addr_wb_valid, .o_local_only, .o_req_error, .o_tx_valid,
  .o_tx_header, .i_ind_valid, .i_rx_src_addr, .i_rx_dest_addr, .i_rx_func_code,
  .i_ind_fc_byte, .o_ind_valid, .o_ind_rem_addr, .o_ind_loc_addr, .o_ind_func_code);
`default_nettype wire

// ===== sim/fbh_request_header_tb_top.sv
// Bench for the header handler: host requests, indications, link back-pressure.
// Assumes the link model and the checker are compiled before it.
`default_nettype none
module fbh_request_header_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fbh_pkg::*;
  logic i_clock = 1'b0, i_rst_b, i_clk_en, i_address_format_select, i_req_valid, i_tx_ready;
  logic i_resp_ptr_read, i_ind_valid, i_rx_src_default, i_rx_dest_default, i_stall;
  logic o_req_ready, o_loc_addr_wb_valid, o_local_only, o_req_error, o_err_l4_cfg, o_err_func;
  logic o_tx_valid, o_ind_valid, saw_err, saw_lo, saw_wb, o_err_length, o_err_reserved;
  logic o_ind_l4_err;
  logic [6:0] i_own_station_address_reg;
  logic [5:0] i_l4_length_one, i_l4_length_two, o_ind_l4_len;
  logic [31:0] i_request_buffer_pointer;
  logic [1:0] i_l4_header_length_select, i_ind_l4_select;
  logic [7:0] i_req_data_length, i_rem_addr, i_loc_addr, i_func_code, i_rem_sap, i_loc_sap;
  logic [7:0] i_rx_src_addr, i_rx_dest_addr, i_rx_func_code, i_rx_src_sap, i_rx_dest_sap;
  logic [7:0] i_ind_fc_byte, o_loc_addr_wb, o_ind_rem_addr, o_ind_loc_addr, o_ind_func_code;
  logic [7:0] o_ind_rem_sap, o_ind_loc_sap, wb;
  tx_header_t o_tx_header;
  int n_fail = 0, samples_checked = 0;
  fbh_request_header fbh_request_header_i (
    .i_clock, .i_rst_b, .i_clk_en, .i_address_format_select, .i_own_station_address_reg,
    .i_l4_length_one, .i_l4_length_two, .i_req_valid, .o_req_ready, .i_request_buffer_pointer,
    .i_req_data_length, .i_rem_addr, .i_loc_addr, .i_func_code, .i_rem_sap, .i_loc_sap,
    .i_l4_header_length_select, .i_resp_ptr_read, .o_loc_addr_wb, .o_loc_addr_wb_valid,
    .o_local_only, .o_req_error, .o_err_length, .o_err_reserved, .o_err_func,
    .o_err_l4_cfg, .o_tx_valid, .i_tx_ready, .o_tx_header, .i_ind_valid, .i_rx_src_addr,
    .i_rx_dest_addr, .i_rx_func_code, .i_rx_src_sap, .i_rx_dest_sap, .i_rx_src_default,
    .i_rx_dest_default, .i_ind_fc_byte, .i_ind_l4_select, .o_ind_valid, .o_ind_rem_addr,
    .o_ind_loc_addr, .o_ind_func_code, .o_ind_rem_sap, .o_ind_loc_sap, .o_ind_l4_len,
    .o_ind_l4_err);
  fbh_link_model fbh_link_model_i (.i_clock, .i_stall, .i_tx_valid(o_tx_valid),
    .i_tx_header(o_tx_header), .o_tx_ready(i_tx_ready));
  always #50 i_clock = ~i_clock;
  task automatic chk(input string what, input logic [TX_HEADER_W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Host side: fields held until taken, then outcome pulses watched for six cycles
  task automatic req(input logic [31:0] p, input logic [7:0] len, ra, la, fc,
                     input logic [1:0] sel);
    int n;
    n = 0;
    i_request_buffer_pointer = p;
    i_req_data_length = len;
    i_rem_addr = ra;
    i_loc_addr = la;
    i_func_code = fc;
    i_l4_header_length_select = sel;
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    @(negedge i_clock);
    i_req_valid = 1'b0;
    {saw_err, saw_lo, saw_wb} = 3'h0;
    repeat (6) begin
      saw_err = saw_err | (o_req_error === 1'b1);
      saw_lo = saw_lo | (o_local_only === 1'b1);
      if (o_loc_addr_wb_valid === 1'b1) begin
        saw_wb = 1'b1;
        wb = o_loc_addr_wb;
      end
      @(negedge i_clock);
    end
  endtask
  task automatic t_send();
    i_address_format_select = 1'b0;
    req(32'hfff12346, 8'hf4, 8'h85, 8'h85, 8'h33, 2'h2);
    chk("send", {saw_err, saw_wb}, 2'h1);
    chk("wb", wb, 8'hc5);
    chk("hdr", fbh_link_model_i.hdr_q[$], {20'h12346, 8'hf4, 8'h85, 8'h95, 8'h33, 8'h21,
      8'h42, 6'h0a, 1'b0});
  endtask
  task automatic t_seg();
    i_address_format_select = 1'b1;
    req({16'h1234, 16'h0010}, 8'hf6, 8'h7f, 8'h00, 8'h34, 2'h1);
    chk("seg", fbh_link_model_i.hdr_q[$], {20'h12350, 8'hf6, 8'h7f, 8'h15, 8'h34, 8'h00,
      8'h00, 6'h02, 1'b1});
  endtask
  task automatic t_errs();
    logic [7:0] len[4] = '{8'hf5, 8'h00, 8'h00, 8'h00};
    logic [7:0] la[4] = '{8'h00, 8'h10, 8'h00, 8'h00};
    logic [7:0] fc[4] = '{8'h03, 8'h03, 8'h07, 8'h03};
    int n;
    n = fbh_link_model_i.hdr_q.size();
    i_l4_length_two = 6'h21;
    for (int k = 0; k < 4; k++) begin
      req(32'h0, len[k], 8'h81, la[k], fc[k], (k == 3) ? 2'h3 : 2'h0);
      chk("err", saw_err, 1'b1);
      chk("cause", {o_err_length, o_err_reserved, o_err_func, o_err_l4_cfg},
        4'h8 >> k);
    end
    i_l4_length_two = 6'h20;
    chk("refused", fbh_link_model_i.hdr_q.size(), n);
  endtask
  task automatic t_codes();
    logic [3:0] code[7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hc, 4'hd};
    for (int k = 0; k < 7; k++) begin
      req(32'h0, 8'h05, 8'h10, 8'h00, {2'h0, k[1:0], code[k]}, 2'h0);
      chk("fc", fbh_link_model_i.hdr_q[$].func_code, {2'h0, k[1:0], code[k]});
    end
  endtask
  task automatic t_local();
    int n;
    n = fbh_link_model_i.hdr_q.size();
    req(32'h0, 8'h00, 8'h10, 8'h00, 8'hc0, 2'h0);
    chk("local", saw_lo, 1'b1);
    chk("not sent", fbh_link_model_i.hdr_q.size(), n);
  endtask
  task automatic t_resp();
    i_resp_ptr_read = 1'b1;
    @(negedge i_clock);
    i_resp_ptr_read = 1'b0;
    chk("rd", {o_loc_addr_wb_valid, o_loc_addr_wb[5]}, 2'h3);
  endtask
  // Three indications back to back: source default point in the first, destination default in the last two
  task automatic t_ind();
    i_ind_valid = 1'b1;
    {i_rx_src_addr, i_rx_dest_addr, i_rx_func_code, i_rx_src_sap, i_rx_dest_sap} = 40'h83043c1122;
    {i_rx_src_default, i_rx_dest_default, i_ind_fc_byte, i_ind_l4_select} = 12'h803;
    @(negedge i_clock);
    chk("ind1", {o_ind_valid, o_ind_rem_addr, o_ind_loc_addr, o_ind_func_code, o_ind_rem_sap,
      o_ind_loc_sap, o_ind_l4_len}, {1'b1, 32'h83040cff, 8'h22, 6'h20});
    {i_rx_src_addr, i_rx_dest_addr, i_rx_func_code, i_rx_src_sap, i_rx_dest_sap} = 40'h0586191122;
    {i_rx_src_default, i_rx_dest_default, i_ind_fc_byte, i_ind_l4_select} = 12'h482;
    @(negedge i_clock);
    {i_ind_l4_select, i_l4_length_two} = {2'h3, 6'h21};
    chk("ind2", {o_ind_valid, o_ind_rem_addr, o_ind_loc_addr, o_ind_func_code, o_ind_rem_sap,
      o_ind_loc_sap, o_ind_l4_len}, {1'b1, 32'h05862911, 8'hff, 6'h0a});
    @(negedge i_clock);
    {i_ind_valid, i_l4_length_two} = {1'b0, 6'h20};
    chk("ind3", {o_ind_l4_err, o_ind_l4_len}, 7'h61);
  endtask
  // Link stalled: eight queued plus one in the output stage, the tenth must wait
  task automatic t_fill();
    int n;
    n = fbh_link_model_i.hdr_q.size();
    i_stall = 1'b1;
    for (int k = 0; k < 10; k++) req(32'h0, k[7:0], 8'h10, 8'h00, 8'h03, 2'h0);
    chk("full", {saw_wb, o_req_ready}, 2'h0);
    i_stall = 1'b0;
    repeat (30) @(negedge i_clock);
    chk("drained", fbh_link_model_i.hdr_q.size(), n + 10);
    chk("order", {fbh_link_model_i.hdr_q[n].data_len, fbh_link_model_i.hdr_q[n + 9].data_len},
      16'h0009);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_stall = 1'b0;
    {i_clk_en, i_address_format_select, i_req_valid, i_resp_ptr_read, i_ind_valid} = 5'h10;
    {i_rx_src_default, i_rx_dest_default, i_ind_l4_select, i_l4_header_length_select} = 6'h0;
    {i_request_buffer_pointer, i_req_data_length, i_rem_addr, i_loc_addr, i_func_code} = '0;
    {i_rx_src_addr, i_rx_dest_addr, i_rx_func_code, i_rx_src_sap, i_rx_dest_sap} = '0;
    i_ind_fc_byte = 8'h00;
    i_own_station_address_reg = 7'h15;
    {i_l4_length_one, i_l4_length_two} = {6'h0a, 6'h20};
    {i_rem_sap, i_loc_sap} = 16'h2142;
    repeat (8) @(negedge i_clock);
    chk("reset", {o_req_ready, o_tx_valid, o_req_error}, 3'h4);
    i_rst_b = 1'b1;
    t_send();
    t_seg();
    t_errs();
    t_codes();
    t_local();
    t_resp();
    t_ind();
    t_fill();
    wrap_up();
  end
  // Whole run is a few hundred cycles; this bound only catches a hang
  initial begin
    #(100 * 5000);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
